// file: bench/core_reset_and_low_power_ctl_test.sv
/* Directed bench: resets, boot paths, level mirrors and sleep/wake.
   Assumes the agent model drives reset and wake pins. */
module core_reset_and_low_power_ctl_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys = 1'b0, resetn = 1'b0, wait_exec = 1'b0;
   logic [31:0] status_word = 32'h0, debug_word = 32'h0;
   logic        warm_reset_low, power_on_reset_low, nmi_in;
   logic [7:0]  int_in;
   logic        core_reset, reset_exception, debug_boot_path;
   logic        kernel_fetch, soft_reset_flag, exception_level_out;
   logic        error_level_out, debug_mode_out, core_clk_en, sleep_out;
   int          n_fail = 0, samples_checked = 0, n_exc = 0;
   int          wake_kind [3] = '{3, 4, 0};
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (reset_exception === 1'b1) n_exc++;
   sys_power_agent agent (.*);
   core_reset_and_low_power_ctl uut (.*);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic wait_exit;
      for (int i = 0; i < 40 && core_reset !== 1'b0; i++) tick(1);
   endtask
   initial begin
      tick(4);
      resetn = 1'b1;
      wait_exit();
      check(kernel_fetch, 1'b0);
      tick(10);
      check(core_reset, 1'b0);
      check(n_exc, 0);
      $display("test idle done");
      // Synced release after the 5th edge; pulse then ends 6 edges later
      agent.drive(0, 3);
      tick(7);
      check(core_reset, 1'b1);
      tick(3);
      check(core_reset, 1'b0);
      check(soft_reset_flag, 1'b1);
      check(debug_boot_path, 1'b1);
      check(n_exc, 1);
      $display("test warm reset done");
      // Cold alone, then cold with warm: warm level must not matter
      for (int k = 1; k < 3; k++) begin
         agent.drive(k, 3);
         tick(2);
         check(kernel_fetch, 1'b1);
         check(debug_boot_path, 1'b0);
         wait_exit();
         check(soft_reset_flag, 1'b0);
         check(n_exc, k + 1);
      end
      $display("test cold reset done");
      for (logic [1:0] v = 2'h1; v != 2'h3; v++) begin
         status_word = {29'h0, v, 1'b0};
         debug_word = {1'b0, v[0], 30'h0};
         tick(1);
         check(exception_level_out, v[0]);
         check(error_level_out, v[1]);
         check(debug_mode_out, v[0]);
      end
      $display("test mirrors done");
      for (int k = 0; k < 3; k++) begin
         wait_exec = 1'b1;
         tick(1);
         wait_exec = 1'b0;
         check(sleep_out, 1'b1);
         check(core_clk_en, 1'b0);
         agent.drive(wake_kind[k], 1);
         tick(3);
         check(sleep_out, 1'b0);
         check(core_clk_en, 1'b1);
         wait_exit();
         tick(4);
      end
      $display("test sleep done");
      resetn = 1'b0;
      tick(2);
      check(kernel_fetch, 1'b1);
      check(core_clk_en, 1'b1);
      $display("test power reset done");
      final_report();
   end
   initial begin
      #50us;
      n_fail++;
      final_report();
   end
endmodule // core_reset_and_low_power_ctl_test

// file: bench/rst_pwr_monitor.sv
/* Concurrent checks on the reset and low-power block ports.
   Assumes one clock, clk_sys, and async active-low resetn. */
module rst_pwr_monitor import rst_pwr_pkg::*; (
   input wire logic clk_sys, resetn, wait_exec, nmi_in, // Inputs
   input wire logic [INT_W-1:0] int_in,        // Interrupt pins
   input wire logic [31:0] status_word, debug_word, // Status words
   input wire logic core_reset, reset_exception, kernel_fetch, // Reset
   input wire logic debug_boot_path, soft_reset_flag, // Boot state
   input wire logic exception_level_out, error_level_out, // Mirrors
   input wire logic debug_mode_out, core_clk_en, sleep_out // Power
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence s_wait_taken;
      wait_exec && !core_reset && !sleep_out && int_in == '0 && !nmi_in;
   endsequence
   sequence s_asleep;
      sleep_out && !core_clk_en;
   endsequence
   a_exl_mirror: assert property ($past(resetn) |->
      exception_level_out == $past(status_word[EXL_POS]))
      else $error("exception level pin wrong");
   a_erl_mirror: assert property ($past(resetn) |->
      error_level_out == $past(status_word[ERL_POS]))
      else $error("error level pin wrong");
   a_dm_mirror: assert property ($past(resetn) |->
      debug_mode_out == $past(debug_word[DM_POS]))
      else $error("debug mode pin wrong");
   a_exc_pulse: assert property (reset_exception |=> !reset_exception)
      else $error("reset exception longer than one cycle");
   a_exc_in_reset: assert property (reset_exception |-> core_reset)
      else $error("reset exception outside reset");
   a_pulse_len: assert property ($rose(core_reset) |-> core_reset[*6])
      else $error("internal reset too short");
   a_cold_boot: assert property (kernel_fetch |->
      !debug_boot_path && !soft_reset_flag)
      else $error("debug boot with cold reset");
   a_sleep_entry: assert property (s_wait_taken |=> s_asleep)
      else $error("wait did not sleep");
   a_clk_gate: assert property (core_clk_en == !sleep_out)
      else $error("clock gate disagrees with sleep");
   a_wake_int: assert property (sleep_out && (int_in != '0 || nmi_in)
      |-> ##[1:4] !sleep_out) else $error("no wake on interrupt");
endmodule // rst_pwr_monitor
bind core_reset_and_low_power_ctl rst_pwr_monitor mon (.*);

// file: bench/sys_power_agent.sv
/* System power agent model: drives the reset, interrupt and NMI pins.
   Assumes the bench calls drive() just after a falling clock edge. */
module sys_power_agent (
   input  wire logic       clk_sys,            // Core clock
   output logic            warm_reset_low,     // Warm reset pin
   output logic            power_on_reset_low, // Cold reset pin
   output logic [7:0]      int_in,             // Interrupt pins
   output logic            nmi_in              // NMI pin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      warm_reset_low = 1'b1;
      power_on_reset_low = 1'b1;
      int_in = 8'h00;
      nmi_in = 1'b0;
   end
   // Kind 0 warm, 1 cold, 2 both, 3 interrupt, 4 NMI; held n cycles
   task automatic drive(input int kind, input int n);
      warm_reset_low = !(kind == 0 || kind == 2);
      power_on_reset_low = !(kind == 1 || kind == 2);
      int_in = (kind == 3) ? 8'h81 : 8'h00;
      nmi_in = (kind == 4);
      repeat (n) @(negedge clk_sys);
      warm_reset_low = 1'b1;
      power_on_reset_low = 1'b1;
      int_in = 8'h00;
      nmi_in = 1'b0;
   endtask
endmodule // sys_power_agent

// file: common/rst_pwr_pkg.sv
/*
 * Constants for the core reset and low-power control block.
 * Assumes a single core clock domain at 20 MHz.
 */
package rst_pwr_pkg;
   localparam int unsigned RESET_PULSE_CYCLES = 6;
   localparam int unsigned CNT_W              = 3;
   localparam int unsigned EXL_POS            = 1;
   localparam int unsigned ERL_POS            = 2;
   localparam int unsigned DM_POS             = 30;
   localparam int unsigned INT_W              = 8;
   localparam logic [2:0]  CNT_RESET          = 3'h0;

   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_RUN   = 2'b01,
      ST_SLEEP = 2'b10
   } pwr_state_t;
endpackage

// file: src/core_reset_and_low_power_ctl.sv
/*
 * Core reset sequencer and power-state control: stretches warm or cold
 * reset into a pulse ending six cycles after release, picks debug boot or kernel fetch,
 * mirrors exception/error/debug level bits on pins, and runs the
 * halt-until-interrupt sleep state with its sleep indication.
 * Assumes the core logic supplies status bits and a wait strobe on
 * clk_sys; reset, interrupt and NMI pins are asynchronous.
 */
// Function
// - Warm and cold low resets, async accepted
// - Internal reset held until six cycles after synced release, synchronous exit
// - Warm-only reset permits debug boot, except while kernel fetch is set
// - Cold reset forbids debug boot, kernel fetch
// - Warm-only reset sets soft reset flag
// - Both high: no reset action
// - Exception level pin follows status bit 1
// - Error level pin follows status bit 2
// - Debug mode pin follows debug bit 30
// - Wait stops core clock; wake inputs live
// - Interrupt, NMI or reset ends sleep
// - Sleep output asserted on wait execution
// - Fully static logic, survives stopped clock
module core_reset_and_low_power_ctl (
   input  wire logic              clk_sys,            // Core clock
   input  wire logic              resetn,             // Async power reset
   input  wire logic              warm_reset_low,     // Warm reset pin
   input  wire logic              power_on_reset_low, // Cold reset pin
   input  wire logic [rst_pwr_pkg::INT_W-1:0] int_in, // Interrupt pins
   input  wire logic              nmi_in,             // NMI pin
   input  wire logic              wait_exec,          // Wait executed
   input  wire logic [31:0]       status_word,        // Status register
   input  wire logic [31:0]       debug_word,         // Debug register
   output logic                   core_reset,         // Internal reset
   output logic                   reset_exception,    // Reset exc pulse
   output logic                   debug_boot_path,    // Debug boot allowed
   output logic                   kernel_fetch,       // Kernel fetch boot
   output logic                   soft_reset_flag,    // Warm reset seen
   output logic                   exception_level_out, // EXCEPTION_LEVEL_BIT mirror
   output logic                   error_level_out,    // ERROR_LEVEL_BIT mirror
   output logic                   debug_mode_out,     // DM mirror
   output logic                   core_clk_en,        // Core clock gate
   output logic                   sleep_out           // Sleeping
);
   import rst_pwr_pkg::*;

   // Two-flop synchronisers for every pin-level input
   logic [INT_W+2:0] sync1_reg;
   logic [INT_W+2:0] sync2_reg;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sync1_reg <= '1;
         sync2_reg <= '1;
      end else begin
         sync1_reg <= {~int_in, ~nmi_in, warm_reset_low,
                       power_on_reset_low};
         sync2_reg <= sync1_reg;
      end
   end

   logic warm_s;
   logic cold_s;
   logic wake_irq;
   assign cold_s   = sync2_reg[0];
   assign warm_s   = sync2_reg[1];
   assign wake_irq = ~(&sync2_reg[INT_W+2:2]);

   // Cold low wins over warm; warm alone is a soft reset
   logic any_reset;
   logic warm_only;
   assign any_reset = ~cold_s | ~warm_s;
   assign warm_only = ~warm_s & cold_s;

   pwr_state_t        state_reg, state_next;
   logic [CNT_W-1:0]  cnt_reg, cnt_next;
   logic              rst_out_reg, rst_out_next;
   logic              exc_reg, exc_next;
   logic              dbg_boot_reg, dbg_boot_next;
   logic              kfetch_reg, kfetch_next;
   logic              srf_reg, srf_next;
   logic              sleep_reg, sleep_next;
   logic              clk_en_reg, clk_en_next;
   logic              was_reset_reg, was_reset_next;
   logic              exl_reg, erl_reg, dm_reg;

   always_comb begin
      state_next     = state_reg;
      cnt_next       = cnt_reg;
      rst_out_next   = rst_out_reg;
      exc_next       = 1'b0;
      dbg_boot_next  = dbg_boot_reg;
      kfetch_next    = kfetch_reg;
      srf_next       = srf_reg;
      sleep_next     = sleep_reg;
      clk_en_next    = clk_en_reg;
      was_reset_next = any_reset;
      if (any_reset) begin
         // Assertion (re)starts the pulse from any state, sleep included
         state_next   = ST_RESET;
         cnt_next     = CNT_RESET;
         rst_out_next = 1'b1;
         sleep_next   = 1'b0;
         clk_en_next  = 1'b1;
         exc_next     = ~was_reset_reg;
         if (!cold_s) begin
            dbg_boot_next = 1'b0;
            kfetch_next   = 1'b1;
            srf_next      = 1'b0;
         end else if (warm_only && kfetch_reg == 1'b0) begin
            dbg_boot_next = 1'b1;
            srf_next      = 1'b1;
         end else if (warm_only) begin
            srf_next      = 1'b1;
         end
      end else begin
         case (state_reg)
            ST_RESET: begin
               // Pulse counted after release; exit on a clock edge
               if (cnt_reg == CNT_W'(RESET_PULSE_CYCLES - 1)) begin
                  state_next   = ST_RUN;
                  rst_out_next = 1'b0;
                  kfetch_next  = 1'b0;
               end else begin
                  cnt_next = cnt_reg + 1'b1;
               end
            end
            ST_RUN: begin
               // Both pins high: nothing but normal running
               if (wait_exec) begin
                  state_next  = ST_SLEEP;
                  sleep_next  = 1'b1;
                  clk_en_next = 1'b0;
               end
            end
            ST_SLEEP: begin
               // This block stays clocked so wake pins are still seen
               if (wake_irq) begin
                  state_next  = ST_RUN;
                  sleep_next  = 1'b0;
                  clk_en_next = 1'b1;
               end
            end
            default: begin
               state_next   = ST_RESET;
               cnt_next     = CNT_RESET;
               rst_out_next = 1'b1;
            end
         endcase
      end
   end

   // Only static flip-flops: state holds if clk_sys slows or stops
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_reg     <= ST_RESET;
         cnt_reg       <= CNT_RESET;
         rst_out_reg   <= 1'b1;
         exc_reg       <= 1'b0;
         dbg_boot_reg  <= 1'b0;
         kfetch_reg    <= 1'b1;
         srf_reg       <= 1'b0;
         sleep_reg     <= 1'b0;
         clk_en_reg    <= 1'b1;
         was_reset_reg <= 1'b0;
      end else begin
         state_reg     <= state_next;
         cnt_reg       <= cnt_next;
         rst_out_reg   <= rst_out_next;
         exc_reg       <= exc_next;
         dbg_boot_reg  <= dbg_boot_next;
         kfetch_reg    <= kfetch_next;
         srf_reg       <= srf_next;
         sleep_reg     <= sleep_next;
         clk_en_reg    <= clk_en_next;
         was_reset_reg <= was_reset_next;
      end
   end

   // Level mirrors, one register stage from the core-side bits
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         exl_reg <= 1'b0;
         erl_reg <= 1'b0;
         dm_reg  <= 1'b0;
      end else begin
         exl_reg <= status_word[EXL_POS];
         erl_reg <= status_word[ERL_POS];
         dm_reg  <= debug_word[DM_POS];
      end
   end

   assign core_reset          = rst_out_reg;
   assign reset_exception     = exc_reg;
   assign debug_boot_path     = dbg_boot_reg;
   assign kernel_fetch        = kfetch_reg;
   assign soft_reset_flag     = srf_reg;
   assign exception_level_out = exl_reg;
   assign error_level_out     = erl_reg;
   assign debug_mode_out      = dm_reg;
   assign core_clk_en         = clk_en_reg;
   assign sleep_out           = sleep_reg;
endmodule // core_reset_and_low_power_ctl
